// [etr_recorder.sv]
/*
  Elapsed-time and event recorder core.
  Assumes a 2-wire front end on the same clock that reports address
  matches and register writes, and a raw asynchronous event pin.
*/
`timescale 1ns/10ps
module etr_recorder #(
  parameter int DEGLITCH_CYC = etr_pkg::DEGLITCH_CYC,
  parameter int FIRST_TICK_CYC = etr_pkg::FIRST_TICK_CYC,
  parameter int TICK_CYC = etr_pkg::TICK_CYC,
  parameter int NV_WRITE_CYC = etr_pkg::NV_WRITE_CYC,
  parameter int NV_LOAD_CYC = etr_pkg::NV_LOAD_CYC
) (
  input wire logic i_clk_sys,                       // System clock
  input wire logic i_rst_n,                         // Async reset, low
  input wire logic i_event_pin,                     // Raw event pin
  input wire logic i_addr_hit,                      // Own address seen
  input wire logic i_alarm_wr,                      // Alarm write strobe
  input wire logic [etr_pkg::ETC_W-1:0] i_alarm_wdata, // Alarm value
  input wire logic i_user_wr,                       // User byte write
  input wire logic [etr_pkg::USER_AW-1:0] i_user_addr, // User byte index
  input wire logic [7:0] i_user_wdata,              // User byte data
  output logic o_addr_ack,                          // Address acknowledge
  output logic o_busy,                              // Port unavailable
  output logic o_event_active,                      // Filtered event
  output logic o_osc_run,                           // Time base running
  output logic [etr_pkg::ETC_W-1:0] o_etc,          // Elapsed time
  output logic [etr_pkg::EVT_W-1:0] o_event_count,  // Event count
  output logic [etr_pkg::ETC_W-1:0] o_alarm_value,  // Alarm value
  output logic [7:0] o_user_rdata,                  // User byte read
  output logic o_alarm_flag                         // Alarm flag
);
  import etr_pkg::*;

  etr_state_type state_reg;
  logic ev_level;
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [CNT_W-1:0] tick_cnt_reg;
  logic first_tick_reg;
  logic tick;
  logic rise;
  logic fall;
  logic hold_done;
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic [ETC_W-1:0] etc_reg;
  logic [EVT_W-1:0] evt_reg;
  logic [ETC_W-1:0] alarm_reg;
  logic [ETC_W-1:0] nv_etc [NV_COPIES];
  logic [EVT_W-1:0] nv_evt [NV_COPIES];
  logic [ETC_W-1:0] nv_alarm_reg;
  logic [7:0] nv_user [USER_BYTES];
  logic [7:0] user_mem [USER_BYTES];
  logic user_ok;

  function automatic logic [ETC_W-1:0] sat_inc(input logic [ETC_W-1:0] v);
    sat_inc = (v == ETC_MAX) ? v : v + 1'b1;
  endfunction

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_LAST) ? PTR_RST : p + 1'b1;
  endfunction

  etr_deglitch #(
    .FILT_CYC(DEGLITCH_CYC)
  ) u_deglitch (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_event_pin),
    .o_level(ev_level)
  );

  // ----------------------------------------------------------------
  // Event sequencing
  // ----------------------------------------------------------------
  assign rise = (state_reg == ST_IDLE) && ev_level;
  assign fall = (state_reg == ST_RUN) && !ev_level;
  assign hold_done = (state_reg == ST_LOAD)
    ? (hold_cnt_reg == CNT_W'(NV_LOAD_CYC - 1))
    : (hold_cnt_reg == CNT_W'(NV_WRITE_CYC - 1));
  assign ptr_next = ptr_inc(ptr_reg);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE: if (ev_level) state_reg <= ST_LOAD;
        ST_LOAD: if (hold_done) state_reg <= ST_RUN;
        ST_RUN: if (!ev_level) state_reg <= ST_STORE;
        ST_STORE: if (hold_done) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Hold-off counter for load and store windows
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      hold_cnt_reg <= CNT_RST;
    else if (o_busy && !hold_done)
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    else
      hold_cnt_reg <= CNT_RST;
  end

  // ----------------------------------------------------------------
  // Time base: runs only from the rising event until the fall
  // ----------------------------------------------------------------
  assign o_osc_run = (state_reg == ST_LOAD) || (state_reg == ST_RUN);
  assign tick = o_osc_run && (first_tick_reg
    ? (tick_cnt_reg == CNT_W'(FIRST_TICK_CYC - 1))
    : (tick_cnt_reg == CNT_W'(TICK_CYC - 1)));

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_reg <= CNT_RST;
      first_tick_reg <= 1'b1;
    end
    else if (!o_osc_run || tick)
    begin
      tick_cnt_reg <= CNT_RST;
      first_tick_reg <= !o_osc_run;
    end
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // Working counters
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      etc_reg <= ETC_RST;
      evt_reg <= EVT_RST;
    end
    else if (rise)
    begin
      etc_reg <= nv_etc[ptr_reg];
      evt_reg <= nv_evt[ptr_reg];
    end
    else if (fall)
      evt_reg <= evt_reg + 1'b1;
    else if (tick)
      etc_reg <= sat_inc(etc_reg);
  end

  // ----------------------------------------------------------------
  // Alarm value and user memory, writable while the port is free, except an alarm write in a rise cycle
  // ----------------------------------------------------------------
  assign user_ok = i_user_addr < USER_AW'(USER_BYTES);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      alarm_reg <= ETC_RST;
    else if (rise)
      alarm_reg <= nv_alarm_reg;
    else if (i_alarm_wr && !o_busy)
      alarm_reg <= i_alarm_wdata;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < USER_BYTES; i++)
        user_mem[i] <= USER_RST;
    end
    else if (i_user_wr && !o_busy && user_ok)
      user_mem[i_user_addr] <= i_user_wdata;
  end

  // ----------------------------------------------------------------
  // Nonvolatile storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ptr_reg <= PTR_RST;
      nv_alarm_reg <= ETC_RST;
      for (int i = 0; i < NV_COPIES; i++)
      begin
        nv_etc[i] <= ETC_RST;
        nv_evt[i] <= EVT_RST;
      end
      for (int i = 0; i < USER_BYTES; i++)
        nv_user[i] <= USER_RST;
    end
    else if (fall)
    begin
      ptr_reg <= ptr_next;
      nv_etc[ptr_next] <= etc_reg;
      nv_evt[ptr_next] <= evt_reg + 1'b1;
      nv_alarm_reg <= alarm_reg;
      for (int i = 0; i < USER_BYTES; i++)
        nv_user[i] <= user_mem[i];
    end
  end

  // ----------------------------------------------------------------
  // Alarm flag: sticky, set only by a nonzero match
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_alarm_flag <= 1'b0;
    else if ((alarm_reg != ETC_RST) && (etc_reg == alarm_reg))
      o_alarm_flag <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Host port availability and outputs
  // ----------------------------------------------------------------
  // Reads during the load would show stale data, so the port is closed
  assign o_busy = (state_reg == ST_LOAD) || (state_reg == ST_STORE);
  assign o_addr_ack = i_addr_hit && !o_busy;
  assign o_event_active = ev_level;
  assign o_etc = etc_reg;
  assign o_event_count = evt_reg;
  assign o_alarm_value = alarm_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_user_rdata <= USER_RST;
    else if (user_ok)
      o_user_rdata <= user_mem[i_user_addr];
    else
      o_user_rdata <= USER_RST;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [ETC_W-1:0] nv_etc_sel;
  assign nv_etc_sel = nv_etc[ptr_reg];

  a_load_rise:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    rise |=> (state_reg == ST_LOAD) && o_osc_run
      && (etc_reg == $past(nv_etc_sel)))
  else $error("Counter not loaded on rising event");

  a_tick_step:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (tick && !rise && !fall && etc_reg != ETC_MAX)
      |=> etc_reg == $past(etc_reg) + 1'b1)
  else $error("Elapsed time did not step on tick");

  a_event_count:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    fall |=> (evt_reg == $past(evt_reg) + 1'b1)
      && (nv_evt[ptr_reg] == evt_reg) && o_busy)
  else $error("Event count not bumped and stored on fall");

  a_nack_busy:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_reg == ST_STORE) |-> !o_addr_ack)
  else $error("Address acknowledged while port closed");

  a_alarm_set:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (alarm_reg != ETC_RST && etc_reg == alarm_reg) |=> o_alarm_flag)
  else $error("Alarm flag missed a match");

  a_alarm_hold:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_alarm_flag |=> o_alarm_flag[*3])
  else $error("Alarm flag cleared");

  a_alarm_zero:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (alarm_reg == ETC_RST && !o_alarm_flag) |=> !o_alarm_flag)
  else $error("Alarm set with zero alarm value");

  a_etc_sat:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (etc_reg == ETC_MAX && !rise) |=> etc_reg == ETC_MAX)
  else $error("Elapsed time wrapped");

  a_osc_stop:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    fall |=> !o_osc_run && !tick)
  else $error("Time base still running after fall");

  a_ptr_rotate:
  assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    fall |=> ptr_reg == ptr_inc($past(ptr_reg)))
  else $error("Storage copy did not rotate");

endmodule // etr_recorder

// [etr_pkg.sv]
/*
  Constants shared by the elapsed-time and event recorder.
  Assumes a 10 MHz system clock; all timing counts derive from it.
*/
package etr_pkg;

  // ----------------------------------------------------------------
  // Widths and storage sizes
  // ----------------------------------------------------------------
  localparam int ETC_W = 32;
  localparam int EVT_W = 17;
  localparam int NV_COPIES = 3;
  localparam int USER_BYTES = 10;
  localparam int USER_AW = 4;
  localparam int CNT_W = 32;
  localparam int PTR_W = 2;

  // ----------------------------------------------------------------
  // Clock rate and times (microseconds)
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int DEGLITCH_TIME_US = 35_000;
  localparam int FIRST_TICK_DELAY_US = 125_000;
  localparam int TICK_INTERVAL_US = 250_000;
  localparam int NV_WRITE_TIME_US = 300_000;
  localparam int NV_LOAD_TIME_US = 1_000;

  localparam int DEGLITCH_CYC = DEGLITCH_TIME_US * CYC_PER_US;
  localparam int FIRST_TICK_CYC = FIRST_TICK_DELAY_US * CYC_PER_US;
  localparam int TICK_CYC = TICK_INTERVAL_US * CYC_PER_US;
  localparam int NV_WRITE_CYC = NV_WRITE_TIME_US * CYC_PER_US;
  localparam int NV_LOAD_CYC = NV_LOAD_TIME_US * CYC_PER_US;

  // ----------------------------------------------------------------
  // Reset values, limits and states
  // ----------------------------------------------------------------
  localparam logic [ETC_W-1:0] ETC_MAX = 32'hffffffff;
  localparam logic [ETC_W-1:0] ETC_RST = 32'h00000000;
  localparam logic [EVT_W-1:0] EVT_RST = 17'h00000;
  localparam logic [7:0] USER_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 2'h0;
  localparam logic [PTR_W-1:0] PTR_LAST = 2'h2;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h00000000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_RUN,
    ST_STORE
  } etr_state_type;

endpackage

// [etr_deglitch.sv]
/*
  Event input synchroniser and deglitch filter.
  Assumes an asynchronous pin; output changes only after the input
  has held a new level for FILT_CYC clock cycles.
*/
`timescale 1ns/10ps
module etr_deglitch #(
  parameter int FILT_CYC = etr_pkg::DEGLITCH_CYC
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n,   // Async reset, active low
  input wire logic i_pin,     // Raw event pin
  output logic o_level        // Filtered level
);
  import etr_pkg::*;

  logic sync1_reg;
  logic sync2_reg;
  logic [CNT_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Stability filter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= CNT_RST;
      o_level <= 1'b0;
    end
    else if (sync2_reg == o_level)
      cnt_reg <= CNT_RST;
    else if (cnt_reg == CNT_W'(FILT_CYC - 1))
    begin
      cnt_reg <= CNT_RST;
      o_level <= sync2_reg;
    end
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

endmodule // etr_deglitch

// [etr_host_model.sv]
/*
  Behavioural far side of the recorder: host front end and event source.
  Assumes the recorder clock. Every request is launched by non-blocking
  assignment at a rising edge.
*/
`timescale 1ns/10ps
module etr_host_model (
  input wire logic i_clk_sys,                        // System clock
  input wire logic i_busy,                           // Port unavailable
  input wire logic i_addr_ack,                       // Address acknowledge
  input wire logic [7:0] i_user_rdata,               // User byte read
  output logic o_event_pin,                          // Raw event pin
  output logic o_addr_hit,                           // Own address seen
  output logic o_alarm_wr,                           // Alarm write strobe
  output logic [etr_pkg::ETC_W-1:0] o_alarm_wdata,   // Alarm value
  output logic o_user_wr,                            // User byte write
  output logic [etr_pkg::USER_AW-1:0] o_user_addr,   // User byte index
  output logic [7:0] o_user_wdata                    // User byte data
);
  import etr_pkg::*;

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial
  begin
    o_event_pin = 1'b0;
    o_addr_hit = 1'b0;
    o_alarm_wr = 1'b0;
    o_user_wr = 1'b0;
  end

  // ----------------------------------------------------------------
  // Host requests
  // ----------------------------------------------------------------
  // A polite host stays off the port during load and store
  task automatic wait_free(input bit polite);
    int k;
    k = 0;
    while (polite && i_busy !== 1'b0 && k < 1000)
    begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
  endtask

  task automatic set_event(input logic v);
    @(posedge i_clk_sys);
    o_event_pin <= v;
  endtask

  task automatic probe(input bit polite, output logic ack);
    wait_free(polite);
    @(posedge i_clk_sys);
    o_addr_hit <= 1'b1;
    #1;
    ack = i_addr_ack;
    @(posedge i_clk_sys);
    o_addr_hit <= 1'b0;
  endtask

  task automatic write_alarm(input bit polite, input logic [31:0] d);
    wait_free(polite);
    @(posedge i_clk_sys);
    o_alarm_wr <= 1'b1;
    o_alarm_wdata <= d;
    @(posedge i_clk_sys);
    o_alarm_wr <= 1'b0;
    o_alarm_wdata <= ~d;
  endtask

  task automatic write_user(input bit polite, input logic [3:0] a,
                            input logic [7:0] d);
    wait_free(polite);
    @(posedge i_clk_sys);
    o_user_wr <= 1'b1;
    o_user_addr <= a;
    o_user_wdata <= d;
    @(posedge i_clk_sys);
    o_user_wr <= 1'b0;
    o_user_wdata <= ~d;
  endtask

  task automatic read_user(input logic [3:0] a, output logic [7:0] d);
    wait_free(1'b1);
    @(posedge i_clk_sys);
    o_user_addr <= a;
    // Read byte is registered: it stands from the edge after the index
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    d = i_user_rdata;
  endtask
endmodule // etr_host_model

// [tb_top.sv]
/*
  Self-checking bench for the recorder core with shortened counts.
  Assumes the host model drives every front-end and event input.
*/
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  import etr_pkg::*;
  localparam int DGL = 4, FT = 20, TK = 40, NVW = 30, NVL = 5;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} etr_row_type;
  etr_row_type rows [4] = '{'{4'h0, 8'ha5, 8'ha5}, '{4'h9, 8'h3c, 8'h3c},
                           '{4'ha, 8'h77, 8'h00}, '{4'hf, 8'h11, 8'h00}};
  logic i_clk_sys, i_rst_n, i_event_pin, i_addr_hit, i_alarm_wr, i_user_wr;
  logic [ETC_W-1:0] i_alarm_wdata, o_etc, o_alarm_value;
  logic [USER_AW-1:0] i_user_addr;
  logic [7:0] i_user_wdata, o_user_rdata;
  logic o_addr_ack, o_busy, o_event_active, o_osc_run, o_alarm_flag;
  logic [EVT_W-1:0] o_event_count;
  int miscompares = 0, checks = 0;

  etr_recorder #(.DEGLITCH_CYC(DGL), .FIRST_TICK_CYC(FT), .TICK_CYC(TK),
    .NV_WRITE_CYC(NVW), .NV_LOAD_CYC(NVL)) uut (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_event_pin(i_event_pin), .i_addr_hit(i_addr_hit),
    .i_alarm_wr(i_alarm_wr), .i_alarm_wdata(i_alarm_wdata),
    .i_user_wr(i_user_wr), .i_user_addr(i_user_addr),
    .i_user_wdata(i_user_wdata), .o_addr_ack(o_addr_ack), .o_busy(o_busy),
    .o_event_active(o_event_active), .o_osc_run(o_osc_run), .o_etc(o_etc),
    .o_event_count(o_event_count), .o_alarm_value(o_alarm_value),
    .o_user_rdata(o_user_rdata), .o_alarm_flag(o_alarm_flag));

  etr_host_model p (.i_clk_sys(i_clk_sys), .i_busy(o_busy),
    .i_addr_ack(o_addr_ack), .o_event_pin(i_event_pin),
    .o_addr_hit(i_addr_hit), .o_alarm_wr(i_alarm_wr),
    .o_alarm_wdata(i_alarm_wdata), .o_user_wr(i_user_wr),
    .o_user_addr(i_user_addr), .o_user_wdata(i_user_wdata),
    .i_user_rdata(o_user_rdata));

  // ----------------------------------------------------------------
  // Clock, helpers and verdict
  // ----------------------------------------------------------------
  initial i_clk_sys = 1'b0;
  always #50 i_clk_sys = ~i_clk_sys;

  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask

  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (o_busy !== v && k < 500)
    begin
      tick();
      k++;
    end
  endtask

  // Cycles until the elapsed time next moves
  task automatic count_etc(output int n);
    logic [ETC_W-1:0] old;
    old = o_etc;
    n = 0;
    while (o_etc === old && n < 500)
    begin
      tick();
      n++;
    end
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    miscompares++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int n;
    logic ack, seen;
    logic [7:0] rd;
    i_rst_n = 1'b0;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    tick();
    `CHK("flag at zero alarm", 1'b0, o_alarm_flag)
    for (int i = 0; i < 4; i++)
    begin
      p.write_user(1'b1, rows[i].a, rows[i].d);
      p.read_user(rows[i].a, rd);
      `CHK("user byte", rows[i].e, rd)
    end
    // Glitch shorter than the filter
    p.set_event(1'b1);
    p.set_event(1'b0);
    seen = 1'b0;
    repeat (15)
    begin
      tick();
      if (o_event_active === 1'b1)
        seen = 1'b1;
    end
    `CHK("glitch seen", 1'b0, seen)
    // Zero-length event, with refused traffic while storing
    p.set_event(1'b1);
    wait_busy(1'b1);
    n = 0;
    while (o_busy === 1'b1 && n < 500)
    begin
      tick();
      n++;
    end
    `CHK("load window", NVL, n)
    // Alarm written while running, so that the fall stores it
    p.write_alarm(1'b1, 32'h00000003);
    tick();
    `CHK("alarm value", 32'h00000003, o_alarm_value)
    p.set_event(1'b0);
    wait_busy(1'b1);
    `CHK("osc after fall", 1'b0, o_osc_run)
    `CHK("event count", 17'h00001, o_event_count)
    p.probe(1'b0, ack);
    `CHK("ack while busy", 1'b0, ack)
    p.write_user(1'b0, 4'h0, 8'hff);
    p.probe(1'b1, ack);
    `CHK("ack when free", 1'b1, ack)
    `CHK("etc short event", 32'h00000000, o_etc)
    p.read_user(4'h0, rd);
    `CHK("user byte busy write", 8'ha5, rd)
    // Long event reaching the alarm
    p.set_event(1'b1);
    wait_busy(1'b1);
    `CHK("osc at rise", 1'b1, o_osc_run)
    `CHK("alarm loaded", 32'h00000003, o_alarm_value)
    count_etc(n);
    `CHK("first tick", FT, n)
    count_etc(n);
    `CHK("tick interval", TK, n)
    n = 0;
    while (o_alarm_flag !== 1'b1 && n < 500)
    begin
      tick();
      n++;
    end
    `CHK("etc at alarm", 32'h00000003, o_etc)
    count_etc(n);
    p.set_event(1'b0);
    wait_busy(1'b1);
    `CHK("event count", 17'h00002, o_event_count)
    n = 0;
    while (o_busy === 1'b1 && n < 500)
    begin
      tick();
      n++;
    end
    `CHK("store window", NVW, n)
    `CHK("etc stored", 32'h00000004, o_etc)
    p.write_alarm(1'b1, 32'h00000000);
    tick();
    `CHK("alarm cleared", 32'h00000000, o_alarm_value)
    `CHK("flag sticky", 1'b1, o_alarm_flag)
    // Third event reads the next rotation slot
    p.set_event(1'b1);
    wait_busy(1'b1);
    `CHK("etc reloaded", 32'h00000004, o_etc)
    p.set_event(1'b0);
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK("event count", 17'h00003, o_event_count)
    // Reset during a load clears working and stored counters
    p.set_event(1'b1);
    wait_busy(1'b1);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    tick();
    `CHK("flag after reset", 1'b0, o_alarm_flag)
    `CHK("busy in reset", 1'b0, o_busy)
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    tick();
    `CHK("etc after reset", 32'h00000000, o_etc)
    wait_busy(1'b1);
    `CHK("etc reload cleared", 32'h00000000, o_etc)
    `CHK("count reload cleared", 17'h00000, o_event_count)
    p.set_event(1'b0);
    wait_busy(1'b0);
    wait_busy(1'b1);
    `CHK("count after reset", 17'h00001, o_event_count)
    results();
  end
endmodule // tb_top
